// file: include/swr_map.vh
`ifndef SWR_MAP_VH
`define SWR_MAP_VH
`define SWR_CLK_MHZ 20
`define SWR_STOP_WAIT_NS 34000
`define SWR_STOP_WAIT_CYC ((`SWR_STOP_WAIT_NS * `SWR_CLK_MHZ) / 1000)
`define SWR_RST_MIN_NS 2000
`define SWR_RST_MIN_CYC ((`SWR_RST_MIN_NS * `SWR_CLK_MHZ + 999) / 1000)
`define SWR_SEL_W 3
`define SWR_SEL_RESET 3'h4
`endif

// file: src/swr_down_counter.v
`timescale 1ns/1ps
module swr_down_counter #(
    parameter W = 16
) (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire load,
    input wire [W-1:0] load_val,
    output reg done_r
);
    reg [W-1:0] cnt_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= {W{1'b0}};
            done_r <= 1'b0;
        end else if (ce) begin
            if (load) begin
                cnt_r <= load_val;
                done_r <= 1'b0;
            end else if (cnt_r != {W{1'b0}}) begin
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
                done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
            end else begin
                done_r <= 1'b0;
            end
        end
    end
endmodule // swr_down_counter

// file: src/swr_standby_ctrl.v
`timescale 1ns/1ps
`include "swr_map.vh"
module swr_standby_ctrl #(
    parameter NSRC = 8,
    parameter CW = 20,
    parameter STOP_WAIT_CYC = `SWR_STOP_WAIT_CYC,
    parameter RST_MIN_CYC = `SWR_RST_MIN_CYC,
    parameter SETTLE_BASE_CYC = 1024
) (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire [NSRC-1:0] irq_req,
    input wire [NSRC-1:0] irq_mask,
    input wire halt_cmd,
    input wire stop_cmd,
    input wire [`SWR_SEL_W-1:0] osc_settle_select,
    input wire [`SWR_SEL_W-1:0] opt_settle_select,
    input wire resonator_used,
    input wire osc_running,
    input wire reset_pin_n,
    input wire int_reset,
    output reg cpu_run_r,
    output reg halt_mode_r,
    output reg stop_mode_r,
    output reg main_osc_en_r,
    output reg lowspeed_osc_en_r,
    output reg sys_reset_r,
    output reg [2:0] state_r
);
    // state codes; RSTHOLD is also the state held in reset
    localparam ST_RUN = 3'h0;
    localparam ST_HALT = 3'h1;
    localparam ST_STOP = 3'h2;
    localparam ST_OSCUP = 3'h3;
    localparam ST_FIXWAIT = 3'h4;
    localparam ST_SETTLE = 3'h5;
    localparam ST_RSTHOLD = 3'h6;

    // three-stage pin synchroniser; only stages 2 and 3 are compared
    reg pin_s1_r;
    reg pin_s2_r;
    reg pin_s3_r;
    reg pin_low_r;
    reg [CW-1:0] low_cnt_r;
    reg ext_reset_r;
    reg rst_seen_r;
    reg [2:0] state_nxt;
    reg load;
    reg [CW-1:0] load_val;
    reg rst_seen_nxt;
    reg cpu_run_nxt;
    reg halt_mode_nxt;
    reg stop_mode_nxt;
    reg sys_reset_nxt;
    reg main_osc_en_nxt;
    reg lowspeed_osc_en_nxt;
    wire [NSRC-1:0] pend;
    wire wake;
    wire cnt_done;
    wire any_reset;
    wire [CW-1:0] run_settle;
    wire [CW-1:0] opt_settle;

    // one pending term per source, ORed into a single wake
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_pend
            assign pend[gi] = irq_req[gi] & ~irq_mask[gi];
        end
    endgenerate
    // not registered: a wake present on the entry edge must still block entry
    assign wake = |pend;
    assign any_reset = ext_reset_r | int_reset;
    // settle time doubles per select step; keeps the choice table small
    assign run_settle = SETTLE_BASE_CYC[CW-1:0] << osc_settle_select;
    assign opt_settle = SETTLE_BASE_CYC[CW-1:0] << opt_settle_select;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_s3_r <= 1'b1;
            pin_low_r <= 1'b0;
        end else if (ce) begin
            pin_s1_r <= reset_pin_n;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r)
                pin_low_r <= ~pin_s3_r;
        end
    end

    // shorter pulses are ignored as glitches
    // count is capped, so a long hold keeps ext_reset_r up
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_r <= {CW{1'b0}};
            ext_reset_r <= 1'b0;
        end else if (ce) begin
            if (!pin_low_r) begin
                low_cnt_r <= {CW{1'b0}};
                ext_reset_r <= 1'b0;
            end else if (low_cnt_r >= RST_MIN_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
                ext_reset_r <= 1'b1;
            end else begin
                low_cnt_r <= low_cnt_r + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // one counter shared by the fixed STOP wait and the settle wait
    swr_down_counter #(.W(CW)) u_wait (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .load(load),
        .load_val(load_val),
        .done_r(cnt_done)
    );

    always @* begin
        state_nxt = state_r;
        load = 1'b0;
        load_val = {CW{1'b0}};
        if (any_reset) begin
            state_nxt = ST_RSTHOLD;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (stop_cmd && !wake)
                        state_nxt = ST_STOP;
                    else if (halt_cmd && !wake)
                        state_nxt = ST_HALT;
                end

                ST_HALT: begin
                    if (wake)
                        state_nxt = ST_RUN;
                end

                ST_STOP: begin
                    if (wake) begin
                        state_nxt = ST_FIXWAIT;
                        load = 1'b1;
                        load_val = STOP_WAIT_CYC[CW-1:0];
                    end
                end

                ST_FIXWAIT: begin
                    // oscillator starts with this wait, so OSCUP is often one cycle
                    if (cnt_done)
                        state_nxt = resonator_used ? ST_OSCUP : ST_RUN;
                end

                ST_OSCUP: begin
                    // settle count begins only now, start-up time excluded
                    if (osc_running) begin
                        state_nxt = ST_SETTLE;
                        load = 1'b1;
                        load_val = rst_seen_r ? opt_settle : run_settle;
                    end
                end

                ST_SETTLE: begin
                    if (cnt_done)
                        state_nxt = ST_RUN;
                end

                ST_RSTHOLD: begin
                    // one hold cycle after the last reset source has gone
                    state_nxt = resonator_used ? ST_OSCUP : ST_RUN;
                end

                default: state_nxt = ST_RSTHOLD;
            endcase
        end
    end

    // outputs follow the next state so each one leaves a flip-flop
    always @* begin
        rst_seen_nxt = rst_seen_r;
        if (state_nxt == ST_RSTHOLD)
            rst_seen_nxt = 1'b1;
        else if (state_nxt == ST_RUN)
            rst_seen_nxt = 1'b0;
        cpu_run_nxt = (state_nxt == ST_RUN);
        halt_mode_nxt = (state_nxt == ST_HALT);
        stop_mode_nxt = (state_nxt == ST_STOP);
        sys_reset_nxt = (state_nxt == ST_RSTHOLD);
        // main oscillator stops in STOP and while reset holds
        main_osc_en_nxt = (state_nxt != ST_RSTHOLD) && (state_nxt != ST_STOP);
        // low-speed clock keeps running through STOP
        lowspeed_osc_en_nxt = (state_nxt != ST_RSTHOLD);
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RSTHOLD;
            rst_seen_r <= 1'b1;
            cpu_run_r <= 1'b0;
            halt_mode_r <= 1'b0;
            stop_mode_r <= 1'b0;
            main_osc_en_r <= 1'b0;
            lowspeed_osc_en_r <= 1'b0;
            sys_reset_r <= 1'b1;
        end else if (ce) begin
            state_r <= state_nxt;
            rst_seen_r <= rst_seen_nxt;
            cpu_run_r <= cpu_run_nxt;
            halt_mode_r <= halt_mode_nxt;
            stop_mode_r <= stop_mode_nxt;
            sys_reset_r <= sys_reset_nxt;
            main_osc_en_r <= main_osc_en_nxt;
            lowspeed_osc_en_r <= lowspeed_osc_en_nxt;
        end
    end
endmodule // swr_standby_ctrl

// file: dv/swr_ctrl_assertions.sv
`timescale 1ns/1ps
module swr_chk #(parameter NSRC = 8) (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire int_reset,
    input wire [NSRC-1:0] irq_req,
    input wire [NSRC-1:0] irq_mask,
    input wire osc_running,
    input wire cpu_run_r,
    input wire halt_mode_r,
    input wire main_osc_en_r,
    input wire lowspeed_osc_en_r,
    input wire sys_reset_r,
    input wire [2:0] state_r
);
    localparam ST_STOP = 3'h2;
    localparam ST_OSCUP = 3'h3;
    localparam ST_FIXWAIT = 3'h4;
    localparam ST_SETTLE = 3'h5;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire wake = |(irq_req & ~irq_mask);
    reg [9:0] fix_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) fix_r <= 10'h000;
        else if (ce) fix_r <= (state_r == ST_FIXWAIT) ? fix_r + 10'h001 : 10'h000;
    end
    sequence s_halt_wake;
        ce && !int_reset && halt_mode_r && wake;
    endsequence
    sequence s_stop_wake;
        ce && !int_reset && state_r == ST_STOP && wake;
    endsequence
    halt_wake_a: assert property (s_halt_wake |=> cpu_run_r && !halt_mode_r)
        else $error("halt not left on wake");
    stop_wake_a: assert property (s_stop_wake |=> state_r == ST_FIXWAIT)
        else $error("stop not left on wake");
    fix_len_a: assert property ($fell(state_r == ST_FIXWAIT) && !sys_reset_r |-> fix_r inside {[10'h2A7:10'h2A9]})
        else $error("fixed stop wait wrong length");
    osc_stop_a: assert property (sys_reset_r |-> !main_osc_en_r && !lowspeed_osc_en_r)
        else $error("oscillator on during reset");
    rst_stop_a: assert property (ce && int_reset |=> sys_reset_r && !main_osc_en_r && !lowspeed_osc_en_r)
        else $error("reset request left oscillator on");
    osc_wait_a: assert property (ce && !int_reset && state_r == ST_OSCUP && !osc_running |=> state_r == ST_OSCUP)
        else $error("settle began before oscillation");
    settle_hold_a: assert property (state_r == ST_SETTLE |-> !cpu_run_r && main_osc_en_r)
        else $error("core ran during settle");
endmodule // swr_chk
bind swr_standby_ctrl swr_chk #(.NSRC(NSRC)) i_swr_chk (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .int_reset(int_reset),
    .irq_req(irq_req),
    .irq_mask(irq_mask),
    .osc_running(osc_running),
    .cpu_run_r(cpu_run_r),
    .halt_mode_r(halt_mode_r),
    .main_osc_en_r(main_osc_en_r),
    .lowspeed_osc_en_r(lowspeed_osc_en_r),
    .sys_reset_r(sys_reset_r),
    .state_r(state_r)
);

// file: dv/swr_osc_model.sv
`timescale 1ns/1ps
module swr_osc_model #(parameter START = 8) (
    input wire clk,
    input wire en,
    output reg running
);
    integer cnt = 0;
    initial running = 1'b0;
    // start-up delay, so a settle count that includes it shows up as too long
    always @(posedge clk) begin
        cnt = en ? cnt + 1 : 0;
        running <= en && cnt >= START;
    end
endmodule // swr_osc_model

// file: dv/swr_standby_ctrl_bench.sv
`timescale 1ns/1ps
`include "swr_map.vh"
module swr_standby_ctrl_bench;
    localparam integer OSC = 8;
    // oscillator starts with the fixed wait, so its start-up hides inside it
    localparam integer EXP = `SWR_STOP_WAIT_CYC + (4 << 7);
    reg clk = 1'b0, nrst = 1'b0, ce = 1'b1, halt_cmd = 1'b0, stop_cmd = 1'b0;
    reg resonator_used = 1'b1, reset_pin_n = 1'b1, int_reset = 1'b0;
    reg [7:0] irq_req = 8'h00, irq_mask = 8'hEF;
    reg [2:0] osc_settle_select = 3'h7, opt_settle_select = 3'h0;
    wire osc_running, cpu_run_r, halt_mode_r, stop_mode_r, main_osc_en_r, lowspeed_osc_en_r, sys_reset_r;
    wire [2:0] state_r;
    integer err_count = 0, compares = 0, n;
    always #25 clk = ~clk;
    swr_standby_ctrl #(.SETTLE_BASE_CYC(4)) i_swr_standby_ctrl (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .irq_req(irq_req),
        .irq_mask(irq_mask),
        .halt_cmd(halt_cmd),
        .stop_cmd(stop_cmd),
        .osc_settle_select(osc_settle_select),
        .opt_settle_select(opt_settle_select),
        .resonator_used(resonator_used),
        .osc_running(osc_running),
        .reset_pin_n(reset_pin_n),
        .int_reset(int_reset),
        .cpu_run_r(cpu_run_r),
        .halt_mode_r(halt_mode_r),
        .stop_mode_r(stop_mode_r),
        .main_osc_en_r(main_osc_en_r),
        .lowspeed_osc_en_r(lowspeed_osc_en_r),
        .sys_reset_r(sys_reset_r),
        .state_r(state_r)
    );
    swr_osc_model #(.START(OSC)) i_swr_osc_model (.clk(clk), .en(main_osc_en_r), .running(osc_running));
    task final_report;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge clk);
        #5;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wait_run;
        n = 0;
        while (cpu_run_r !== 1'b1) begin
            cyc(1);
            n = n + 1;
            if (n > 3000) begin
                err_count = err_count + 1;
                final_report;
            end
        end
    endtask
    initial begin
        cyc(20);
        nrst = 1'b1;
        wait_run;
        chk(n <= OSC + 12, 1);
        $display("reset release done");
        irq_mask = 8'hFF;
        halt_cmd = 1'b1;
        cyc(1);
        halt_cmd = 1'b0;
        irq_req = 8'h10;
        cyc(3);
        chk(halt_mode_r, 1);
        irq_mask = 8'hEF;
        cyc(1);
        chk(cpu_run_r, 1);
        halt_cmd = 1'b1;
        cyc(2);
        chk({halt_mode_r, cpu_run_r}, 2'h1);
        {halt_cmd, irq_req, stop_cmd} = {1'b0, 8'h00, 1'b1};
        cyc(1);
        stop_cmd = 1'b0;
        cyc(1);
        chk({stop_mode_r, main_osc_en_r, state_r}, 5'h12);
        irq_req = 8'h10;
        wait_run;
        chk(n >= EXP && n <= EXP + 8, 1);
        $display("standby done");
        reset_pin_n = 1'b0;
        cyc(20);
        reset_pin_n = 1'b1;
        cyc(5);
        chk(sys_reset_r, 0);
        reset_pin_n = 1'b0;
        cyc(50);
        chk({sys_reset_r, main_osc_en_r, lowspeed_osc_en_r}, 3'h4);
        reset_pin_n = 1'b1;
        wait_run;
        int_reset = 1'b1;
        cyc(4);
        chk({sys_reset_r, main_osc_en_r, lowspeed_osc_en_r}, 3'h4);
        int_reset = 1'b0;
        wait_run;
        $display("reset done");
        irq_req = 8'h00;
        ce = 1'b0;
        halt_cmd = 1'b1;
        cyc(3);
        chk({halt_mode_r, cpu_run_r}, 2'h1);
        ce = 1'b1;
        cyc(1);
        halt_cmd = 1'b0;
        chk(halt_mode_r, 1);
        irq_req = 8'h10;
        cyc(1);
        chk(cpu_run_r, 1);
        $display("clock enable done");
        resonator_used = 1'b0;
        {halt_cmd, irq_req, stop_cmd} = {1'b1, 8'h00, 1'b1};
        cyc(1);
        {halt_cmd, stop_cmd} = 2'h0;
        cyc(1);
        chk({stop_mode_r, halt_mode_r, state_r}, 5'h12);
        irq_req = 8'h10;
        wait_run;
        chk(n >= `SWR_STOP_WAIT_CYC && n <= `SWR_STOP_WAIT_CYC + 8, 1);
        $display("no resonator done");
        final_report;
    end
endmodule // swr_standby_ctrl_bench
